// ===== hdl/asd_cfg.svh
// Constants of the address space decoder: map bounds, register layout, reset values.
// Assumes a single 200 MHz system clock and a plain register port.
//
// Overview of operation
// [R1] ROM-enabled: 0x0-0x3FFFF is on-chip ROM, 32-bit
// [R2] ROM-enabled: space 0 and 4 are 2 MB
// [R3] Spaces 1-3, 5-7 are fixed 4 MB windows
// [R4] ROM-disabled: spaces 0 and 4 are 4 MB
// [R5] Peripheral area 8/16-bit, on-chip RAM 32-bit
// [R6] Masters never access reserved ranges
// [R7] Single-chip mode: no external spaces
// [R8] Spaces 4-7 reserved on flash variant
// [R9] ROM-disabled: spaces 0/4 width from mode pin
// [R10] Other space widths come from the register
// [R11] Software writes low byte once after reset
// [R12] No space access before register setup
// [R13] Small variant: software keeps widths at 16 or less
// [R14] Bit 15,12-8 read 0, bit 14 reads 1
// [R15] Bit 13 gates timer register access, resets 1
// [R16] Bit 7 forces 32-bit for spaces 3/7
// [R17] Bits 6,5,4 force 32-bit for pairs 2,1,0
// [R18] Size bits choose 8 or 16 bit, reset 1
// [R19] Pair 0/4 longword bit only when ROM enabled
// [R20] Chip selects decoded only for top byte 0 or 1
// [R21] Reserved or absent space starts no external cycle
`ifndef ASD_CFG_SVH
`define ASD_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ASD_REG_BUS_CTRL_FIRST   4'h0
`define ASD_REG_STATUS           4'h4
`define ASD_BCF_RESET            16'h600F
`define ASD_BCF_FIXED_MASK       16'hDF00
`define ASD_BCF_FIXED_VAL        16'h4000
`define ASD_BIT_TIMER_EN         13
`define ASD_BIT_LG0              4
`define ASD_BIT_SZ0              0

// ----------------------------------------
// Address map
// ----------------------------------------
`define ASD_ROM_LAST             32'h0003FFFF
`define ASD_PERIPH_FIRST         32'hFFFF8000
`define ASD_PERIPH_LAST          32'hFFFFBFFF
`define ASD_RAM_FIRST            32'hFFFFE000
`define ASD_EXT_TOP0             8'h00
`define ASD_EXT_TOP1             8'h01
`define ASD_HALF_BIT             21

`endif

// ===== hdl/asd_pkg.sv
// Types of the address space decoder.
// Assumes asd_cfg.svh is compiled alongside.
package asd_pkg;

	typedef enum logic [2:0]
	{
		ASD_TGT_NONE   = 3'h0,
		ASD_TGT_ROM    = 3'h1,
		ASD_TGT_EXT    = 3'h3,
		ASD_TGT_PERIPH = 3'h2,
		ASD_TGT_RAM    = 3'h6
	} asd_target_t;

	typedef enum logic [1:0]
	{
		ASD_W8  = 2'h0,
		ASD_W16 = 2'h1,
		ASD_W32 = 2'h2
	} asd_width_t;

	// Result of one decoded access
	typedef struct packed
	{
		asd_target_t target;
		logic [7:0]  chip_select_n;
		asd_width_t  width;
		logic [21:0] ext_addr;
		logic        timer_access;
	} asd_decode_t;

endpackage

// ===== hdl/asd_decoder.sv
// Address space decoder: maps a 32-bit internal address to on-chip and
// external chip-select spaces and holds the first bus control register.
// Assumes synchronous inputs on clk_sys and mode straps stable after reset.
`timescale 1ns/1ps
`default_nettype none
`include "asd_cfg.svh"

module asd_decoder
(
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	// Mode straps
	input  wire logic                rom_enabled,
	input  wire logic                single_chip,
	input  wire logic                cs4_7_present,
	input  wire logic                wide_variant,
	input  wire logic                mode_pin_width,
	// Access request from the bus masters
	input  wire logic                acc_valid,
	input  wire logic [31:0]         acc_addr,
	input  wire logic                acc_timer_regs,
	// Register port
	input  wire logic [3:0]          reg_addr,
	input  wire logic [15:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [15:0]         reg_rdata,
	// Decode result
	output asd_pkg::asd_decode_t     dec_out,
	output logic                     dec_valid,
	output logic                     timer_regs_access_enable
);
	import asd_pkg::*;

	// ----------------------------------------
	// Width selection
	// ----------------------------------------
	function automatic asd_width_t pair_width(input logic lg, input logic sz);
		if (lg)
			pair_width = ASD_W32;
		else if (sz)
			pair_width = ASD_W16;
		else
			pair_width = ASD_W8;
	endfunction

	// ----------------------------------------
	// Bus control register
	// ----------------------------------------
	logic [15:0] bus_control_first_q;
	logic [15:0] bcf_d;
	logic [15:0] bcf_view;
	logic [15:0] stat_view;
	logic        wr_bcf;
	logic        rd_bcf;
	logic        rd_stat;
	logic [15:0] rdata_d;

	assign wr_bcf  = reg_wr && (reg_addr == `ASD_REG_BUS_CTRL_FIRST);
	assign rd_bcf  = reg_rd && (reg_addr == `ASD_REG_BUS_CTRL_FIRST);
	assign rd_stat = reg_rd && (reg_addr == `ASD_REG_STATUS);

	// Fixed bits take their constant values whatever is written; see [R14]
	// Longword bits are held 0 on the small variant; see [R16]
	assign bcf_d = ((reg_wdata & ~`ASD_BCF_FIXED_MASK) | `ASD_BCF_FIXED_VAL)
		& (wide_variant ? 16'hFFFF : 16'hFF0F);
	assign bcf_view = (bus_control_first_q & ~`ASD_BCF_FIXED_MASK) | `ASD_BCF_FIXED_VAL;
	assign stat_view = {11'h000, wide_variant, cs4_7_present, single_chip, rom_enabled, mode_pin_width};

	always_comb
	begin
		if (rd_bcf)
			rdata_d = bcf_view;
		else if (rd_stat)
			rdata_d = stat_view;
		else
			rdata_d = 16'h0000;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			bus_control_first_q <= `ASD_BCF_RESET; // see [R15] see [R18]
		else if (wr_bcf)
			bus_control_first_q <= bcf_d;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= rdata_d;
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic [7:0]  top;
	logic [1:0]  cs_sel;
	logic [2:0]  cs_idx;
	logic        ext_zone;
	logic        ext_ok;
	logic        in_rom;
	logic        in_periph;
	logic        in_ram;
	logic [1:0]  pair;
	logic        pair_lg;
	logic        pair_sz;
	asd_width_t  ext_width;
	asd_width_t  pin_width;
	asd_decode_t dec_d;

	assign top      = acc_addr[31:24];
	assign cs_sel   = acc_addr[23:22]; // see [R20]
	assign cs_idx   = {top[0], cs_sel};
	assign ext_zone = (top == `ASD_EXT_TOP0) || (top == `ASD_EXT_TOP1); // see [R20]
	assign in_rom   = rom_enabled && (acc_addr <= `ASD_ROM_LAST); // see [R1]
	assign in_periph = (acc_addr >= `ASD_PERIPH_FIRST) && (acc_addr <= `ASD_PERIPH_LAST); // see [R5]
	assign in_ram   = acc_addr >= `ASD_RAM_FIRST; // see [R5]

	// Space 0/4 is half size when ROM is enabled; the low half is reserved; see [R2] see [R4]
	// Spaces 1-3 and 5-7 are always full 4 MB windows; see [R3]
	// External spaces are absent in single chip mode, 4-7 absent on flash; see [R7] see [R8]
	assign ext_ok = ext_zone && !single_chip
		&& !(top[0] && !cs4_7_present)
		&& !(cs_sel == 2'h0 && rom_enabled && !acc_addr[`ASD_HALF_BIT]); // see [R21]

	assign pair    = cs_sel;
	assign pair_lg = bus_control_first_q[`ASD_BIT_LG0 + pair]; // see [R17] see [R16]
	assign pair_sz = bus_control_first_q[`ASD_BIT_SZ0 + pair]; // see [R18]

	// Pin picks 8/16 on the small variant, 16/32 on the wide one; see [R9]
	assign pin_width = wide_variant ? (mode_pin_width ? ASD_W32 : ASD_W16)
		: (mode_pin_width ? ASD_W16 : ASD_W8);

	// Pair 0/4 longword bit ignored in ROM-disabled mode; see [R19] see [R10]
	assign ext_width = (pair == 2'h0 && !rom_enabled) ? pin_width : pair_width(pair_lg, pair_sz);

	always_comb
	begin
		dec_d = '0;
		dec_d.chip_select_n = 8'hFF;
		dec_d.target = ASD_TGT_NONE;
		dec_d.width = ASD_W32;
		dec_d.ext_addr = acc_addr[21:0];
		dec_d.timer_access = acc_timer_regs && bus_control_first_q[`ASD_BIT_TIMER_EN]; // see [R15]
		if (in_rom)
		begin
			dec_d.target = ASD_TGT_ROM;
			dec_d.width = ASD_W32;
		end
		else if (ext_ok)
		begin
			dec_d.target = ASD_TGT_EXT;
			dec_d.width = ext_width;
			dec_d.chip_select_n = ~(8'h01 << cs_idx);
		end
		else if (in_periph)
		begin
			dec_d.target = ASD_TGT_PERIPH;
			dec_d.width = ASD_W16;
		end
		else if (in_ram)
		begin
			dec_d.target = ASD_TGT_RAM;
			dec_d.width = ASD_W32;
		end
		// Reserved ranges fall through with no select; see [R6] see [R21]
		if (!acc_valid)
		begin
			dec_d.chip_select_n = 8'hFF;
			dec_d.timer_access = 1'b0;
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			dec_out <= '{target: ASD_TGT_NONE, chip_select_n: 8'hFF, width: ASD_W32,
				ext_addr: 22'h000000, timer_access: 1'b0};
			dec_valid <= 1'b0;
			timer_regs_access_enable <= 1'b1;
		end
		else
		begin
			dec_out <= dec_d;
			dec_valid <= acc_valid;
			timer_regs_access_enable <= bus_control_first_q[`ASD_BIT_TIMER_EN];
		end
	end

endmodule
`default_nettype wire

// ===== test/asd_chk.sv
// Port checker of the address space decoder.
// Assumes it is bound to asd_decoder and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module asd_chk
	import asd_pkg::*;
(
	// Clock, reset and straps
	input wire logic                 clk_sys,
	input wire logic                 rst_n,
	input wire logic                 rom_enabled,
	input wire logic                 single_chip,
	input wire logic                 cs4_7_present,
	// Access and register port
	input wire logic                 acc_valid,
	input wire logic [31:0]          acc_addr,
	input wire logic [3:0]           reg_addr,
	input wire logic                 reg_rd,
	input wire logic [15:0]          reg_rdata,
	// Decode result
	input wire asd_pkg::asd_decode_t dec_out,
	input wire logic                 dec_valid,
	input wire logic                 timer_regs_access_enable
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_ext;
		acc_valid && !single_chip && !rom_enabled && acc_addr[31:25] == 7'h00 && (cs4_7_present || !acc_addr[24]);
	endsequence
	sequence s_sel;
		dec_valid && dec_out.chip_select_n == ~(8'h01 << $past(acc_addr[24:22])) && dec_out.ext_addr == $past(acc_addr[21:0]);
	endsequence

	property p_fixed;
		reg_rd && reg_addr == 4'h0 |=> reg_rdata[15:14] == 2'h1 && reg_rdata[12:8] == 5'h00;
	endproperty
	property p_timer;
		dec_out.timer_access |-> timer_regs_access_enable;
	endproperty
	property p_cs_ext;
		dec_out.target != ASD_TGT_EXT |-> dec_out.chip_select_n == 8'hFF;
	endproperty
	property p_rsv;
		acc_valid && acc_addr[31:25] != 7'h00 && acc_addr < 32'hFFFF8000 |=> dec_out.target == ASD_TGT_NONE;
	endproperty
	property p_single;
		acc_valid && single_chip |=> dec_out.chip_select_n == 8'hFF;
	endproperty
	property p_no_hi;
		acc_valid && !cs4_7_present && acc_addr[31:24] == 8'h01 |=> dec_out.chip_select_n == 8'hFF;
	endproperty
	property p_ram;
		acc_valid && acc_addr >= 32'hFFFFE000 |=> dec_out.target == ASD_TGT_RAM && dec_out.width == ASD_W32;
	endproperty
	property p_rom;
		acc_valid && rom_enabled && acc_addr <= 32'h0003FFFF |=> dec_out.target == ASD_TGT_ROM && dec_out.width == ASD_W32;
	endproperty
	property p_sel;
		s_ext |=> s_sel;
	endproperty

	a_fixed: assert property (p_fixed) else $error("fixed register bits wrong");
	a_timer: assert property (p_timer) else $error("timer access while disabled");
	a_cs_ext: assert property (p_cs_ext) else $error("select outside external space");
	a_rsv: assert property (p_rsv) else $error("reserved range decoded");
	a_single: assert property (p_single) else $error("select in single-chip mode");
	a_no_hi: assert property (p_no_hi) else $error("absent upper space selected");
	a_ram: assert property (p_ram) else $error("on-chip RAM decode wrong");
	a_rom: assert property (p_rom) else $error("on-chip ROM decode wrong");
	a_sel: assert property (p_sel) else $error("select or external address wrong");
endmodule

`default_nettype wire

// ===== test/asd_ext_mem.sv
// External memory side: records which chip selects were driven.
// Assumes decode results registered on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module asd_ext_mem
	import asd_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// Select lines from the decoder
	input  wire asd_pkg::asd_decode_t dec_out,
	input  wire logic                 dec_valid,
	output logic [7:0]                sel_seen_q
);
	// ----------------------------------------
	// Select history, one device per line
	// ----------------------------------------
	always_ff @(posedge clk_sys)
		if (!rst_n)
			sel_seen_q <= 8'h00;
		else if (dec_valid)
			sel_seen_q <= sel_seen_q | ~dec_out.chip_select_n;
endmodule

`default_nettype wire

// ===== test/asd_decoder_test.sv
// Testbench of the address space decoder.
// Assumes asd_pkg, asd_decoder, asd_chk and asd_ext_mem are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t mismatch", $time); end end

module asd_decoder_test;
	import asd_pkg::*;
	logic        clk_sys = 1'b0, rst_n = 1'b0, acc_valid = 1'b0, acc_timer_regs = 1'b1;
	logic        rom_enabled = 1'b1, single_chip = 1'b0, cs4_7_present = 1'b1, wide_variant = 1'b1;
	logic        mode_pin_width = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, dec_valid, timer_regs_access_enable;
	logic [31:0] acc_addr = 32'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0, reg_rdata;
	logic [7:0]  sel_seen_q;
	asd_decode_t dec_out;
	int          fails = 0, n_checks = 0;

	asd_decoder DUT (.clk_sys, .rst_n, .rom_enabled, .single_chip, .cs4_7_present, .wide_variant, .mode_pin_width,
		.acc_valid, .acc_addr, .acc_timer_regs, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.dec_out, .dec_valid, .timer_regs_access_enable);
	asd_ext_mem u_mem (.clk_sys, .rst_n, .dec_out, .dec_valid, .sel_seen_q);

	initial forever #2.5 clk_sys = ~clk_sys;
	initial
	begin
		#20000;
		fails++;
		wrap_up;
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	task automatic md(input logic [4:0] m);
		@(posedge clk_sys);
		{rom_enabled, single_chip, cs4_7_present, wide_variant, mode_pin_width} <= m;
	endtask
	task automatic acc(input logic [31:0] a, input asd_target_t t, input logic [7:0] cs, input asd_width_t w);
		@(posedge clk_sys);
		acc_valid <= 1'b1;
		acc_addr <= a;
		@(posedge clk_sys);
		acc_valid <= 1'b0;
		#1;
		`CHK(dec_valid, 1'b1)
		`CHK(dec_out.target, t)
		`CHK(dec_out.chip_select_n, cs)
		`CHK(dec_out.ext_addr, a[21:0])
		if (t != ASD_TGT_NONE)
			`CHK(dec_out.width, w)
	endtask
	task automatic wrap_up;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(4'h0, 16'h600F);
		`CHK(timer_regs_access_enable, 1'b1)
		acc(32'h00000010, ASD_TGT_ROM, 8'hFF, ASD_W32);
		`CHK(dec_out.timer_access, 1'b1)
		wr(4'h0, 16'h0000);
		rd(4'h0, 16'h4000);
		`CHK(timer_regs_access_enable, 1'b0)
		acc(32'hFFFF8000, ASD_TGT_PERIPH, 8'hFF, ASD_W16);
		`CHK(dec_out.timer_access, 1'b0)
		wr(4'h0, 16'hFFFF);
		rd(4'h0, 16'h60FF);
		`CHK(timer_regs_access_enable, 1'b1)
		@(posedge clk_sys);
		acc_timer_regs <= 1'b0;
		acc(32'h00000010, ASD_TGT_ROM, 8'hFF, ASD_W32);
		`CHK(dec_out.timer_access, 1'b0)
		rd(4'h8, 16'h0000);
		rd(4'h4, 16'h001A);
		$display("test registers done");
		wr(4'h0, 16'h60A6);
		acc(32'h00300000, ASD_TGT_EXT, 8'hFE, ASD_W8);
		acc(32'h00400000, ASD_TGT_EXT, 8'hFD, ASD_W32);
		acc(32'h00800000, ASD_TGT_EXT, 8'hFB, ASD_W16);
		acc(32'h00C00000, ASD_TGT_EXT, 8'hF7, ASD_W32);
		acc(32'h01300000, ASD_TGT_EXT, 8'hEF, ASD_W8);
		acc(32'h01C00000, ASD_TGT_EXT, 8'h7F, ASD_W32);
		acc(32'h00100000, ASD_TGT_NONE, 8'hFF, ASD_W32);
		acc(32'h01000000, ASD_TGT_NONE, 8'hFF, ASD_W32);
		acc(32'h02000000, ASD_TGT_NONE, 8'hFF, ASD_W32);
		acc(32'hFFFFC000, ASD_TGT_NONE, 8'hFF, ASD_W32);
		acc(32'hFFFFE000, ASD_TGT_RAM, 8'hFF, ASD_W32);
		`CHK(sel_seen_q, 8'h9F)
		$display("test enabled map done");
		md(5'b00111);
		acc(32'h00000000, ASD_TGT_EXT, 8'hFE, ASD_W32);
		acc(32'h01000000, ASD_TGT_EXT, 8'hEF, ASD_W32);
		md(5'b00110);
		acc(32'h00000000, ASD_TGT_EXT, 8'hFE, ASD_W16);
		md(5'b00100);
		acc(32'h01000000, ASD_TGT_EXT, 8'hEF, ASD_W8);
		wr(4'h0, 16'h60FF);
		rd(4'h0, 16'h600F);
		acc(32'h00400000, ASD_TGT_EXT, 8'hFD, ASD_W16);
		md(5'b00000);
		acc(32'h01400000, ASD_TGT_NONE, 8'hFF, ASD_W32);
		md(5'b01100);
		acc(32'h00400000, ASD_TGT_NONE, 8'hFF, ASD_W32);
		acc(32'hFFFFE000, ASD_TGT_RAM, 8'hFF, ASD_W32);
		$display("test disabled map done");
		wrap_up;
	end
endmodule

bind asd_decoder asd_chk u_chk (.clk_sys, .rst_n, .rom_enabled, .single_chip, .cs4_7_present, .acc_valid,
	.acc_addr, .reg_addr, .reg_rd, .reg_rdata, .dec_out, .dec_valid, .timer_regs_access_enable);

`default_nettype wire
